// ### rtl/tce_pkg.sv
/*
  constants, register map and carrier types of the terminal capability
  and endpoint retrieval command block.
  assumes one 100 MHz clock and a 32-bit apb register bus.
*/
package tce_pkg;
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_DIN = 12'h004;
  localparam logic [11:0] ADDR_DOUT = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00C;
  localparam logic [11:0] ADDR_CAP = 12'h010;
  localparam logic [11:0] ADDR_EPADDR = 12'h014;
  localparam logic [11:0] ADDR_EPDATA = 12'h018;
  localparam logic [11:0] ADDR_EPCFG = 12'h01C;
  localparam logic [11:0] ADDR_CHCFG = 12'h020;

  localparam logic [7:0] TAG_CAP = 8'hA9;
  localparam logic [7:0] TAG_PWR = 8'h80;
  localparam logic [7:0] TAG_EXT = 8'h81;
  localparam logic [7:0] TAG_IFC = 8'h82;
  localparam logic [7:0] CUR_MIN = 8'h0A;
  localparam logic [7:0] CUR_MAX = 8'h3C;
  localparam logic [7:0] FREQ_NONE = 8'hFF;

  localparam logic [7:0] SC_RETRIEVE = 8'h00;
  localparam logic [7:0] SC_MASTER = 8'h01;
  localparam logic [7:0] SC_TERMINATE = 8'h04;
  localparam logic [1:0] BLK_FIRST = 2'h2;
  localparam logic [1:0] BLK_NEXT = 2'h0;
  localparam logic [1:0] BLK_RETX = 2'h1;
  localparam logic [1:0] BLK_RFU = 2'h3;
  localparam logic [10:0] BLK_MAX = 11'h0FF;

  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [7:0] SW_MORE = 8'h61;
  localparam logic [15:0] SW_BADP = 16'h6B00;
  localparam logic [15:0] SW_NOFUNC = 16'h6A81;
  localparam logic [15:0] SW_BADDATA = 16'h6A80;
  localparam logic [15:0] SW_PEND = 16'h0000;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [17:0] RST_CFG = 18'h0_0000;

  typedef struct packed {
    logic via_ch;
    logic sc_cmd;
    logic [7:0] lc;
    logic [7:0] p2;
    logic [7:0] p1;
  } tce_cmd_type;

  typedef struct packed {
    logic cur_ok;
    logic freq_ind;
    logic clf;
    logic ext_seen;
    logic pwr_seen;
    logic [7:0] freq;
    logic [7:0] current;
    logic [7:0] supply;
  } tce_cap_type;

  typedef enum logic [1:0] {SRC_REG, SRC_BLK, SRC_CAP} tce_src_type;
endpackage

// ### rtl/tce_cap.sv
/*
  byte-serial parser of the terminal capability container.
  assumes bytes arrive one per in_valid after a start pulse.
*/
module tce_cap (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [7:0] lc,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output tce_pkg::tce_cap_type cap,
  output logic done,
  output logic err
);
  typedef enum logic [2:0] {
    S_IDLE, S_OTAG, S_OLEN, S_TAG, S_TAGX, S_LEN, S_VAL
  } tce_cst_type;

  tce_cst_type st_q, st_d;
  logic [7:0] lc_left_q, lc_left_d, out_q, out_d;
  logic [7:0] tag_q, tag_d, len_q, len_d;
  logic [1:0] idx_q, idx_d;
  tce_pkg::tce_cap_type cap_q, cap_d;
  logic done_q, done_d, err_q, err_d;

  wire logic take = in_valid && st_q != S_IDLE;
  wire logic last = lc_left_q == 8'h01;

  always_comb begin
    st_d = st_q;
    lc_left_d = lc_left_q;
    out_d = out_q;
    tag_d = tag_q;
    len_d = len_q;
    idx_d = idx_q;
    cap_d = cap_q;
    done_d = done_q;
    err_d = err_q;
    if (start) begin
      st_d = S_OTAG;
      lc_left_d = lc;
      cap_d = '0;
      done_d = 1'h0;
      err_d = 1'h0;
    end else if (take) begin
      lc_left_d = lc_left_q - 8'h01;
      if ((st_q == S_TAGX || st_q == S_LEN) && out_q == 8'h00) begin
        err_d = 1'h1;
      end
      case (st_q)
        S_OTAG: begin
          if (in_byte == tce_pkg::TAG_CAP) st_d = S_OLEN;
          else err_d = 1'h1;
        end
        S_OLEN: begin
          out_d = in_byte;
          st_d = S_TAG;
          if (in_byte != lc_left_q - 8'h01) err_d = 1'h1;
        end
        S_TAG: begin
          out_d = out_q - 8'h01;
          tag_d = in_byte;
          // private tags may run over several bytes
          st_d = (in_byte[4:0] == 5'h1F) ? S_TAGX : S_LEN;
        end
        S_TAGX: begin
          out_d = out_q - 8'h01;
          if (!in_byte[7]) st_d = S_LEN;
        end
        S_LEN: begin
          out_d = out_q - 8'h01;
          len_d = in_byte;
          idx_d = 2'h0;
          st_d = (in_byte == 8'h00) ? S_TAG : S_VAL;
          if (in_byte > out_q - 8'h01) err_d = 1'h1;
          // content after the length is skipped
          if (tag_q == tce_pkg::TAG_EXT) cap_d.ext_seen = 1'h1;
        end
        S_VAL: begin
          out_d = out_q - 8'h01;
          len_d = len_q - 8'h01;
          if (idx_q != 2'h3) idx_d = idx_q + 2'h1;
          if (len_q == 8'h01) st_d = S_TAG;
          if (tag_q == tce_pkg::TAG_PWR) begin
            case (idx_q)
              2'h0: cap_d.supply = in_byte;
              2'h1: begin
                cap_d.current = in_byte;
                cap_d.cur_ok = in_byte >= tce_pkg::CUR_MIN &&
                  in_byte <= tce_pkg::CUR_MAX;
              end
              2'h2: begin
                cap_d.freq = in_byte;
                cap_d.freq_ind = in_byte != tce_pkg::FREQ_NONE;
                cap_d.pwr_seen = 1'h1;
              end
              default: ;
            endcase
          end
          if (tag_q == tce_pkg::TAG_IFC && idx_q == 2'h0) begin
            cap_d.clf = in_byte[0];
          end
        end
        default: ;
      endcase
      if (st_d == S_TAG && out_d == 8'h00 && !err_d) begin
        done_d = 1'h1;
        st_d = S_IDLE;
      end else if (last) begin
        err_d = 1'h1;
      end
      if (err_d) st_d = S_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      lc_left_q <= 8'h00;
      out_q <= 8'h00;
      tag_q <= 8'h00;
      len_q <= 8'h00;
      idx_q <= 2'h0;
      cap_q <= '0;
      done_q <= 1'h0;
      err_q <= 1'h0;
    end else begin
      st_q <= st_d;
      lc_left_q <= lc_left_d;
      out_q <= out_d;
      tag_q <= tag_d;
      len_q <= len_d;
      idx_q <= idx_d;
      cap_q <= cap_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  assign cap = cap_q;
  assign done = done_q;
  assign err = err_q;

  AST_TAG_A9: assert property (@(posedge pclk) disable iff (!presetn)
    take && !start && st_q == S_OTAG && in_byte != tce_pkg::TAG_CAP
    |=> err && st_q == S_IDLE)
    else $error("wrong container tag not refused");
  AST_EXT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    take && !start && st_q == S_LEN && tag_q == tce_pkg::TAG_EXT &&
    out_q != 8'h00 && in_byte <= out_q - 8'h01
    |=> cap.ext_seen && !err)
    else $error("extended channel object not taken");
  AST_CLF_IGN: assert property (@(posedge pclk) disable iff (!presetn)
    take && !start && st_q == S_VAL && tag_q == tce_pkg::TAG_IFC &&
    idx_q != 2'h0 |=> $stable(cap.clf))
    else $error("extra interface byte changed flag");
endmodule // tce_cap

// ### rtl/tce_blk.sv
/*
  block sequencer of the endpoint response: first, next, retransmit.
  assumes total never changes between the blocks of one response.
*/
module tce_blk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [1:0] mode,
  input wire logic [10:0] total,
  input wire logic pop,
  output logic [10:0] idx,
  output logic [7:0] left,
  output logic more,
  output logic [7:0] sw2
);
  function automatic logic [7:0] cap255(input logic [10:0] n);
    cap255 = (n > tce_pkg::BLK_MAX) ? 8'hFF : n[7:0];
  endfunction

  logic [10:0] idx_q, bstart_q, end_q;
  logic [7:0] left_q, sw2_q;
  logic more_q;

  wire logic [10:0] base = (mode == tce_pkg::BLK_FIRST) ? 11'h000 :
    (mode == tce_pkg::BLK_NEXT) ? end_q : bstart_q;
  wire logic [10:0] rem = (base >= total) ? 11'h000 : total - base;
  wire logic [7:0] len = cap255(rem);
  wire logic big = rem > tce_pkg::BLK_MAX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= 11'h000;
      bstart_q <= 11'h000;
      end_q <= 11'h000;
      left_q <= 8'h00;
      more_q <= 1'h0;
      sw2_q <= 8'h00;
    end else if (start) begin
      idx_q <= base;
      bstart_q <= base;
      end_q <= base + {3'h0, len};
      left_q <= len;
      more_q <= big;
      // next Le the terminal should use
      sw2_q <= big ? cap255(rem - tce_pkg::BLK_MAX) : 8'h00;
    end else if (pop && left_q != 8'h00) begin
      idx_q <= idx_q + 11'h001;
      left_q <= left_q - 8'h01;
    end
  end

  assign idx = idx_q;
  assign left = left_q;
  assign more = more_q;
  assign sw2 = sw2_q;

  AST_BLK_MORE: assert property (@(posedge pclk) disable iff (!presetn)
    start && rem > 11'h0FF |=> left == 8'hFF && more)
    else $error("long remainder not cut to 255");
  AST_BLK_LAST: assert property (@(posedge pclk) disable iff (!presetn)
    start && rem <= 11'h0FF |=> left == $past(rem[7:0]) && !more)
    else $error("short remainder not sent whole");
  AST_BLK_RETX: assert property (@(posedge pclk) disable iff (!presetn)
    start && mode == 2'h1 |=> idx == $past(bstart_q))
    else $error("retransmit does not repeat block");
endmodule // tce_blk

// ### rtl/tce_top.sv
/*
  apb slave wrapping the capability parser and endpoint response blocks.
  assumes the card transport writes each command header to CMD, feeds
  command data through DIN and reads response bytes from DOUT.
*/
// Implementation choices: the address map and the APB register port.
// Summary of operation
// - capability data sits in one A9 container with one-byte length
// - private objects with both top tag bits set are accepted
// - supply class coded as in answer-to-reset, unused bits reserved
// - clock byte in 0,1 MHz steps; FF means no frequency given
// - extended channel object treated as zero length, content ignored
// - interface object tag 82 length 01; bit b1 means frontend supported
// - bytes beyond the defined interface content are ignored
// - secure channel command picks sub-procedure from first parameter byte
// - over a secure channel only that channel's endpoints are reported
// - no endpoints: only the count object with value zero
// - one endpoint information object per available endpoint
// - over 255 bytes left: send 255, status says more data
// - at most 255 left: send all, status normal completion
// - count field is binary number of endpoint objects, zero none
module tce_top #(
  parameter int EP_DEPTH = 1024
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ext_chan_en,
  output logic clf_en
);
  localparam int AW = $clog2(EP_DEPTH);

  if (EP_DEPTH < 4 || EP_DEPTH > 1024 || (1 << AW) != EP_DEPTH) begin
    $error("EP_DEPTH must be a power of two from 4 to 1024");
  end

  logic [7:0] ep_mem [EP_DEPTH];
  tce_pkg::tce_cmd_type cmd_q;
  tce_pkg::tce_src_type src_q;
  logic [15:0] sw_q;
  logic [AW-1:0] wptr_q;
  logic [17:0] epcfg_q, chcfg_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  tce_pkg::tce_cap_type cap;
  logic cap_done, cap_err, blk_more;
  logic [10:0] blk_idx;
  logic [7:0] blk_left, blk_sw2;

  // one wait state so every read word comes from a flop
  wire logic setup_acc = psel & penable & ~pready_q;
  wire logic fire = psel & penable & pready_q;
  wire logic wr = fire & pwrite;
  wire logic rd = fire & ~pwrite;

  wire logic hit_cmd = paddr == tce_pkg::ADDR_CMD;
  wire logic hit_din = paddr == tce_pkg::ADDR_DIN;
  wire logic hit_dout = paddr == tce_pkg::ADDR_DOUT;
  wire logic hit_stat = paddr == tce_pkg::ADDR_STAT;
  wire logic hit_cap = paddr == tce_pkg::ADDR_CAP;
  wire logic hit_epaddr = paddr == tce_pkg::ADDR_EPADDR;
  wire logic hit_epdata = paddr == tce_pkg::ADDR_EPDATA;
  wire logic hit_epcfg = paddr == tce_pkg::ADDR_EPCFG;
  wire logic hit_chcfg = paddr == tce_pkg::ADDR_CHCFG;
  wire logic mapped = hit_cmd | hit_din | hit_dout | hit_stat | hit_cap |
    hit_epaddr | hit_epdata | hit_epcfg | hit_chcfg;

  wire tce_pkg::tce_cmd_type nc = tce_pkg::tce_cmd_type'(pwdata[25:0]);
  wire logic cmd_wr = wr & hit_cmd;
  wire logic cap_cmd_ok = ~nc.sc_cmd && nc.p1 == 8'h00 &&
    nc.p2 == 8'h00 && nc.lc != 8'h00;
  wire logic ret_cmd = nc.sc_cmd && nc.p1 == tce_pkg::SC_RETRIEVE &&
    nc.p2[7:6] != tce_pkg::BLK_RFU;
  wire logic nofunc = nc.sc_cmd && nc.p1 >= tce_pkg::SC_MASTER &&
    nc.p1 <= tce_pkg::SC_TERMINATE;
  wire logic cap_start = cmd_wr & cap_cmd_ok;
  wire logic blk_start = cmd_wr & ret_cmd;

  // an image loaded for the channel end stands apart
  wire logic via = cmd_wr ? nc.via_ch : cmd_q.via_ch;
  wire logic [17:0] act_cfg = via ? chcfg_q : epcfg_q;
  wire logic [7:0] ep_cnt = act_cfg[7:0];
  wire logic [10:0] img_base = via ? 11'(EP_DEPTH / 2) : 11'h000;
  wire logic [10:0] total = (ep_cnt == 8'h00) ? 11'h001 :
    {1'h0, act_cfg[17:8]} + 11'h001;
  wire logic [10:0] rd_full = img_base + blk_idx - 11'h001;
  wire logic [AW-1:0] rd_addr = rd_full[AW-1:0];
  wire logic [7:0] dout_byte = (blk_idx == 11'h000) ? ep_cnt :
    ep_mem[rd_addr];
  wire logic dout_ok = src_q == tce_pkg::SRC_BLK && blk_left != 8'h00;
  wire logic [31:0] dout_word = {23'h00_0000, dout_ok, dout_byte};

  wire logic [15:0] sw_eff = (src_q == tce_pkg::SRC_BLK) ?
    (blk_more ? {tce_pkg::SW_MORE, blk_sw2} : tce_pkg::SW_OK) :
    (src_q == tce_pkg::SRC_CAP) ? (cap_err ? tce_pkg::SW_BADDATA :
    cap_done ? tce_pkg::SW_OK : tce_pkg::SW_PEND) : sw_q;
  wire logic busy = src_q == tce_pkg::SRC_CAP & ~cap_done & ~cap_err;
  wire logic [31:0] stat_word = {7'h00, busy, blk_left, sw_eff};

  wire logic [31:0] rd_word = hit_dout ? dout_word :
    hit_stat ? stat_word :
    hit_cap ? {3'h0, cap} :
    hit_cmd ? {6'h00, cmd_q} :
    hit_epaddr ? 32'(wptr_q) :
    hit_epcfg ? {14'h0000, epcfg_q} :
    hit_chcfg ? {14'h0000, chcfg_q} : tce_pkg::RST_WORD;

  wire logic din_valid = wr & hit_din & src_q == tce_pkg::SRC_CAP;
  wire logic pop = rd & hit_dout & src_q == tce_pkg::SRC_BLK;
  wire logic ep_wr = wr & hit_epdata;

  wire tce_pkg::tce_src_type src_new = cap_cmd_ok ? tce_pkg::SRC_CAP :
    ret_cmd ? tce_pkg::SRC_BLK : tce_pkg::SRC_REG;
  wire logic [15:0] sw_new = nofunc ? tce_pkg::SW_NOFUNC :
    tce_pkg::SW_BADP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= tce_pkg::RST_WORD;
    end else begin
      pready_q <= setup_acc;
      pslverr_q <= setup_acc & ~mapped;
      prdata_q <= setup_acc ? rd_word : tce_pkg::RST_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
      src_q <= tce_pkg::SRC_REG;
      sw_q <= tce_pkg::SW_OK;
    end else if (cmd_wr) begin
      cmd_q <= nc;
      src_q <= src_new;
      sw_q <= sw_new;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      epcfg_q <= tce_pkg::RST_CFG;
      chcfg_q <= tce_pkg::RST_CFG;
    end else begin
      if (wr & hit_epaddr) wptr_q <= pwdata[AW-1:0];
      else if (ep_wr) wptr_q <= wptr_q + AW'(1);
      if (wr & hit_epcfg) epcfg_q <= pwdata[17:0];
      if (wr & hit_chcfg) chcfg_q <= pwdata[17:0];
    end
  end

  // endpoint images carry no reset: software loads them before use
  always_ff @(posedge pclk) begin
    if (ep_wr) ep_mem[wptr_q] <= pwdata[7:0];
  end

  tce_cap u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .start(cap_start),
    .lc(nc.lc),
    .in_valid(din_valid),
    .in_byte(pwdata[7:0]),
    .cap(cap),
    .done(cap_done),
    .err(cap_err)
  );

  tce_blk u_blk (
    .pclk(pclk),
    .presetn(presetn),
    .start(blk_start),
    .mode(nc.p2[7:6]),
    .total(total),
    .pop(pop),
    .idx(blk_idx),
    .left(blk_left),
    .more(blk_more),
    .sw2(blk_sw2)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ext_chan_en = cap.ext_seen;
  assign clf_en = cap.clf;

  // helper counters, read only by the checks below
  logic [7:0] fed_q, popped_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fed_q <= 8'h00;
    end else if (cap_start) begin
      fed_q <= 8'h00;
    end else if (din_valid) begin
      fed_q <= fed_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      popped_q <= 8'h00;
    end else if (blk_start) begin
      popped_q <= 8'h00;
    end else if (pop && dout_ok) begin
      popped_q <= popped_q + 8'h01;
    end
  end

  AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    setup_acc |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  AST_CAP_PARAM: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && !nc.sc_cmd && (nc.p1 != 8'h00 || nc.p2 != 8'h00)
    |=> sw_eff == tce_pkg::SW_BADP && !busy)
    else $error("capability parameters not checked");
  AST_SC_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && nofunc |=> sw_eff == tce_pkg::SW_NOFUNC && $stable(blk_left))
    else $error("omitted sub-procedure not refused");
  AST_RFU_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && nc.sc_cmd && nc.p1 == 8'h00 && nc.p2[7:6] == 2'h3
    |=> sw_eff == tce_pkg::SW_BADP && $stable(blk_idx))
    else $error("reserved block pattern accepted");
  AST_NO_EP: assert property (@(posedge pclk) disable iff (!presetn)
    blk_start && ep_cnt == 8'h00 && nc.p2[7:6] == 2'h2
    |=> blk_left == 8'h01 && dout_byte == 8'h00 && sw_eff == 16'h9000)
    else $error("empty endpoint list not a lone count");
  AST_CLF_BIT: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(clf_en) |-> $past(din_valid && pwdata[0]))
    else $error("frontend flag rose without its bit");

  // answers carry data or error only while ready stands
  AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    fire |-> pslverr == !mapped)
    else $error("error answer wrong");
  AST_APB_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == tce_pkg::RST_WORD && !pslverr)
    else $error("answer outside ready");
  AST_CAP_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cap_done) |-> fed_q == cmd_q.lc)
    else $error("container end not at last byte");
  AST_CAP_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    cap_start |=> !ext_chan_en && !clf_en && busy)
    else $error("stale capability flags");
  AST_EXT_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ext_chan_en) |-> $past(din_valid))
    else $error("channel flag rose without data");
  AST_PWR_SEEN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cap.pwr_seen) |-> $past(din_valid))
    else $error("power flag rose without data");
  AST_CAP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    src_q == tce_pkg::SRC_CAP && !busy && din_valid |=> $stable(cap))
    else $error("bytes after parse end taken");
  AST_POP_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    pop && dout_ok |=> blk_left == $past(blk_left) - 8'h01)
    else $error("response byte not consumed");
  AST_BLK_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    src_q == tce_pkg::SRC_BLK |-> 9'(popped_q) + 9'(blk_left) <= 9'h0FF)
    else $error("block over 255 bytes");
  AST_BLK_END: assert property (@(posedge pclk) disable iff (!presetn)
    src_q == tce_pkg::SRC_BLK && !blk_more && blk_left == 8'h00
    |-> blk_idx >= total)
    else $error("final block ended short");
  AST_SC_BADP: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && nc.sc_cmd && nc.p1 > tce_pkg::SC_TERMINATE
    |=> sw_eff == tce_pkg::SW_BADP)
    else $error("unknown sub-procedure accepted");
  AST_NEXT_SW2: assert property (@(posedge pclk) disable iff (!presetn)
    blk_start |=> !blk_more || blk_sw2 != 8'h00)
    else $error("more data with zero length");
  AST_DOUT_CNT: assert property (@(posedge pclk) disable iff (!presetn)
    blk_start && nc.p2[7:6] == tce_pkg::BLK_FIRST
    |=> blk_idx == 11'h000 && dout_byte == ep_cnt)
    else $error("count byte not first");
  AST_EP_PTR: assert property (@(posedge pclk) disable iff (!presetn)
    ep_wr |=> wptr_q == $past(wptr_q) + AW'(1))
    else $error("image pointer did not advance");

  // scenarios a full run should reach
  COV_MORE: cover property (@(posedge pclk) disable iff (!presetn)
    src_q == tce_pkg::SRC_BLK && blk_more && pop);
  COV_CAP_DONE: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(cap_done) && cap.pwr_seen);
  COV_RETX: cover property (@(posedge pclk) disable iff (!presetn)
    blk_start && nc.p2[7:6] == 2'h1);
  COV_NO_EP: cover property (@(posedge pclk) disable iff (!presetn)
    blk_start && ep_cnt == 8'h00);
  COV_CAP_ERR: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(cap_err));
endmodule // tce_top

// ### bench/tce_term.sv
/*
  terminal model: apb master that issues command units to the card.
  assumes it is called right after a rising pclk edge.
*/
module tce_term (
  input wire logic pclk,
  input wire logic presetn,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    // inverted idle values, so a stale bus never looks valid
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask

  // capabilities go out before any selection in the session
  // expected length is not carried on this bus
  task automatic cap_cmd(input logic [15:0] p, input logic [7:0] b[$]);
    wr(tce_pkg::ADDR_CMD, {8'h00, 8'(b.size()), p});
    foreach (b[i]) wr(tce_pkg::ADDR_DIN, {24'h0, b[i]});
  endtask
endmodule // tce_term

// ### bench/tce_top_tb.sv
/*
  self-checking bench of the capability and endpoint command block.
  assumes the terminal model drives apb and tce_pkg is compiled first.
*/
module tce_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr;
  logic ext_chan_en, clf_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e;
  logic [7:0] exp_q[$];
  int fails;
  int tests_run;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  tce_term u_tce_term (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  tce_top #(.EP_DEPTH(1024)) u_tce_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_chan_en(ext_chan_en), .clf_en(clf_en));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic rd(input logic [11:0] a);
    u_tce_term.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_tce_term.wr(a, d);
  endtask

  function automatic logic [7:0] img(int i);
    return 8'((i * 7) + 3);
  endfunction

  task automatic load(input int base, input logic [7:0] cnt,
      input int len, input logic [11:0] cfg);
    wr(tce_pkg::ADDR_EPADDR, 32'(base));
    exp_q = {cnt};
    for (int i = 0; i < len; i++) begin
      wr(tce_pkg::ADDR_EPDATA, {24'h0, img(i + base)});
      exp_q.push_back(img(i + base));
    end
    wr(cfg, {14'h0, 10'(len), cnt});
  endtask

  // one command, then the whole block and one read past its end
  task automatic blk(input logic [31:0] cmd, input logic [15:0] sw,
      input int off, input int n);
    wr(tce_pkg::ADDR_CMD, cmd);
    rd(tce_pkg::ADDR_STAT);
    chk({16'h0, r[15:0]}, {16'h0, sw});
    chk({24'h0, r[23:16]}, 32'(n));
    for (int k = 0; k < n; k++) begin
      rd(tce_pkg::ADDR_DOUT);
      chk({23'h0, r[8:0]}, {23'h0, 1'b1, exp_q[off + k]});
    end
    rd(tce_pkg::ADDR_DOUT);
    chk({31'h0, r[8]}, 32'h0);
  endtask

  task automatic t_reset();
    rd(tce_pkg::ADDR_STAT);
    chk({16'h0, r[15:0]}, {16'h0, tce_pkg::SW_OK});
    chk({30'h0, ext_chan_en, clf_en}, 32'h0);
    rd(12'h024);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0000_0000);
    $display("test reset and bus done");
  endtask

  task automatic t_cap_good();
    // ext object with content, interface object with extra byte,
    // private object last
    u_tce_term.cap_cmd(16'h0000, '{8'hA9, 8'h10, 8'h80, 8'h03, 8'h01,
      8'h3C, 8'hFF, 8'h81, 8'h02, 8'hAA, 8'hBB, 8'h82, 8'h02, 8'h01,
      8'h55, 8'hC1, 8'h01, 8'h00});
    rd(tce_pkg::ADDR_STAT);
    chk({16'h0, r[15:0]}, {16'h0, tce_pkg::SW_OK});
    rd(tce_pkg::ADDR_CAP);
    chk(r, 32'h17FF_3C01);
    chk({30'h0, ext_chan_en, clf_en}, 32'h3);
    $display("test capability full done");
  endtask

  task automatic t_cap_odd();
    u_tce_term.cap_cmd(16'h0000, '{8'hA9, 8'h08, 8'h80, 8'h03, 8'h02,
      8'h09, 8'h0A, 8'h82, 8'h01, 8'hFE});
    rd(tce_pkg::ADDR_STAT);
    chk({16'h0, r[15:0]}, {16'h0, tce_pkg::SW_OK});
    rd(tce_pkg::ADDR_CAP);
    chk(r, 32'h090A_0902);
    chk({30'h0, ext_chan_en, clf_en}, 32'h0);
    u_tce_term.cap_cmd(16'h0000, '{8'hA8, 8'h01, 8'h00});
    rd(tce_pkg::ADDR_STAT);
    chk({16'h0, r[15:0]}, {16'h0, tce_pkg::SW_BADDATA});
    u_tce_term.cap_cmd(16'h0001, '{8'hA9, 8'h00});
    rd(tce_pkg::ADDR_STAT);
    chk({16'h0, r[15:0]}, {16'h0, tce_pkg::SW_BADP});
    $display("test capability odd done");
  endtask

  task automatic t_sc_codes();
    for (int p = 1; p <= 4; p++) begin
      blk({24'h01_0000, 8'(p)}, tce_pkg::SW_NOFUNC, 0, 0);
    end
    blk(32'h0100_0005, tce_pkg::SW_BADP, 0, 0);
    blk(32'h0100_C000, tce_pkg::SW_BADP, 0, 0);
    $display("test selector codes done");
  endtask

  task automatic t_ep_long();
    // 301 bytes: two blocks, second block of 46
    load(0, 8'h02, 300, tce_pkg::ADDR_EPCFG);
    blk(32'h0100_8000, {tce_pkg::SW_MORE, 8'h2E}, 0, 255);
    blk(32'h0100_4000, {tce_pkg::SW_MORE, 8'h2E}, 0, 255);
    blk(32'h0100_0000, tce_pkg::SW_OK, 255, 46);
    blk(32'h0100_0000, tce_pkg::SW_OK, 0, 0);
    $display("test endpoint blocks done");
  endtask

  task automatic t_ep_small();
    load(512, 8'h01, 3, tce_pkg::ADDR_CHCFG);
    blk(32'h0300_8000, tce_pkg::SW_OK, 0, 4);
    // image present but count zero: only the count byte comes back
    load(0, 8'h00, 5, tce_pkg::ADDR_EPCFG);
    blk(32'h0100_8000, tce_pkg::SW_OK, 0, 1);
    $display("test endpoint small done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end

  initial begin
    fails = 0;
    tests_run = 0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_cap_good();
    t_cap_odd();
    t_sc_codes();
    t_ep_long();
    t_ep_small();
    print_verdict();
  end
endmodule // tce_top_tb
